/* File: rtl/fbc_defines.svh */
// timing constants and reset values for the fault blink code display
`ifndef FBC_DEFINES_SVH
`define FBC_DEFINES_SVH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define FBC_CLK_KHZ 64'd50_000

// ----------------------------------------------------------------
// times in milliseconds
// ----------------------------------------------------------------
`define FBC_WAKE_MS 64'd3_000
`define FBC_PRESS_WIN_MS 64'd5_000
`define FBC_RESTORE_WIN_MS 64'd3_000
`define FBC_TIMEOUT_MS 64'd300_000
`define FBC_DEBOUNCE_MS 64'd20
`define FBC_TENS_ON_MS 64'd250
`define FBC_TENS_GAP_MS 64'd250
`define FBC_ONES_ON_MS 64'd350
`define FBC_ONES_GAP_MS 64'd350
`define FBC_SHORT_PAUSE_MS 64'd1_000
`define FBC_LONG_PAUSE_MS 64'd2_500

// ----------------------------------------------------------------
// derived cycle counts
// ----------------------------------------------------------------
`define FBC_WAKE_CYC (`FBC_WAKE_MS * `FBC_CLK_KHZ)
`define FBC_PRESS_WIN_CYC (`FBC_PRESS_WIN_MS * `FBC_CLK_KHZ)
`define FBC_RESTORE_WIN_CYC (`FBC_RESTORE_WIN_MS * `FBC_CLK_KHZ)
`define FBC_TIMEOUT_CYC (`FBC_TIMEOUT_MS * `FBC_CLK_KHZ)
`define FBC_DEBOUNCE_CYC (`FBC_DEBOUNCE_MS * `FBC_CLK_KHZ)
`define FBC_TENS_ON_CYC (`FBC_TENS_ON_MS * `FBC_CLK_KHZ)
`define FBC_TENS_GAP_CYC (`FBC_TENS_GAP_MS * `FBC_CLK_KHZ)
`define FBC_ONES_ON_CYC (`FBC_ONES_ON_MS * `FBC_CLK_KHZ)
`define FBC_ONES_GAP_CYC (`FBC_ONES_GAP_MS * `FBC_CLK_KHZ)
`define FBC_SHORT_PAUSE_CYC (`FBC_SHORT_PAUSE_MS * `FBC_CLK_KHZ)
`define FBC_LONG_PAUSE_CYC (`FBC_LONG_PAUSE_MS * `FBC_CLK_KHZ)

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FBC_LOG_FIRST_RST 3'h0
`define FBC_LOG_TENS_RST 3'h0
`define FBC_LOG_ONES_RST 4'h0

`endif

/* File: rtl/fbc_pkg.sv */
// types shared by the fault blink code display
package fbc_pkg;

    // ------------------------------------------------------------
    // state and phase encodings
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FBC_SLEEP = 3'b000,
        FBC_WAKE = 3'b001,
        FBC_AWAKE = 3'b010,
        FBC_SHOW1 = 3'b011,
        FBC_SHOW2 = 3'b100,
        FBC_TMO = 3'b101
    } fbc_state_e;

    typedef enum logic [1:0] {
        FBC_PH_ON = 2'b00,
        FBC_PH_GAP = 2'b01,
        FBC_PH_PAUSE = 2'b10
    } fbc_phase_e;

    typedef enum logic [2:0] {
        FBC_KIND_NONE = 3'b000,
        FBC_KIND_TEMP = 3'b001,
        FBC_KIND_OIL = 3'b010,
        FBC_KIND_SERVICE = 3'b011,
        FBC_KIND_CRANK = 3'b100
    } fbc_kind_e;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        fbc_kind_e kind;
        logic [2:0] tens;
        logic [3:0] ones;
    } fbc_fault_evt_s;

    typedef struct packed {
        logic [2:0] first;
        logic [2:0] tens;
        logic [3:0] ones;
    } fbc_log_s;

endpackage : fbc_pkg

/* File: rtl/fbc_debounce.sv */
// synchroniser and debouncer for one active-low pushbutton input
`timescale 1ns/1ps
`include "fbc_defines.svh"

module fbc_debounce #(
    parameter int CNT_W = 20,
    parameter logic [CNT_W-1:0] DB_CYC = CNT_W'(`FBC_DEBOUNCE_CYC)
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic raw_n,
    output logic pressed
);
    logic sync1_reg;
    logic sync2_reg;
    logic stable_reg;
    logic [CNT_W-1:0] cnt_reg;
    wire logic differs = ~sync2_reg != stable_reg;
    wire logic settled = cnt_reg == DB_CYC - 1'b1;

    // ------------------------------------------------------------
    // sync and filter
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            stable_reg <= 1'b0;
            cnt_reg <= '0;
        end
        else
        begin
            sync1_reg <= raw_n;
            sync2_reg <= sync1_reg;
            // level must hold a full debounce time before it is believed
            cnt_reg <= (differs && !settled) ? cnt_reg + 1'b1 : '0;
            if (differs && settled)
                stable_reg <= ~sync2_reg;
        end
    end

    assign pressed = stable_reg;

endmodule : fbc_debounce

/* File: rtl/fbc_top.sv */
// fault log and blink code display driven by the stop/prime button
`timescale 1ns/1ps
`include "fbc_defines.svh"

// Functional notes
// - long stop press wakes the controller; lamp lights after the hold time
// - three presses within five seconds start first-level code display
// - first-level code: 1-4 blinks then long pause, repeated
// - code one means coolant over-temperature shutdown
// - code two means low oil pressure shutdown
// - code three means service fault with second-level code stored
// - code four means overcrank beyond thirty seconds
// - one press during first-level display switches to second-level code
// - one press during second-level display ends the blinking
// - second-level: tens 1-5 blinks, short pause, ones 1-9 blinks
// - ones digit blinks slower than tens digit
// - long pause between groups, short pause between digits
// - blinking stops after five minutes of display
// - after timeout three presses within three seconds restart blinking
// - last logged fault kept and shown after condition clears
// - external auto-start stop is a normal shutdown, nothing logged
// - any second-level fault logs first-level service code
module fbc_top
    import fbc_pkg::*;
#(
    parameter logic [27:0] WAKE_CYC = 28'(`FBC_WAKE_CYC),
    parameter logic [27:0] PRESS_WIN_CYC = 28'(`FBC_PRESS_WIN_CYC),
    parameter logic [27:0] RESTORE_WIN_CYC = 28'(`FBC_RESTORE_WIN_CYC),
    parameter logic [35:0] TIMEOUT_CYC = 36'(`FBC_TIMEOUT_CYC),
    parameter logic [19:0] DEBOUNCE_CYC = 20'(`FBC_DEBOUNCE_CYC),
    parameter logic [27:0] TENS_ON_CYC = 28'(`FBC_TENS_ON_CYC),
    parameter logic [27:0] TENS_GAP_CYC = 28'(`FBC_TENS_GAP_CYC),
    parameter logic [27:0] ONES_ON_CYC = 28'(`FBC_ONES_ON_CYC),
    parameter logic [27:0] ONES_GAP_CYC = 28'(`FBC_ONES_GAP_CYC),
    parameter logic [27:0] SHORT_PAUSE_CYC = 28'(`FBC_SHORT_PAUSE_CYC),
    parameter logic [27:0] LONG_PAUSE_CYC = 28'(`FBC_LONG_PAUSE_CYC)
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic local_stop_n,
    input wire logic remote_stop_n,
    input wire logic auto_stop_req,
    input wire fbc_pkg::fbc_fault_evt_s fault_evt,
    output logic status_lamp,
    output logic normal_stop,
    output logic fault_stop,
    output fbc_pkg::fbc_log_s fault_log
);
    import fbc_pkg::*;

    // ------------------------------------------------------------
    // button conditioning
    // ------------------------------------------------------------
    logic local_pressed;
    logic remote_pressed;
    logic stop_prev_reg;

    fbc_debounce #(.CNT_W(20), .DB_CYC(DEBOUNCE_CYC)) u_db_local (
        .core_clk(core_clk),
        .nrst(nrst),
        .raw_n(local_stop_n),
        .pressed(local_pressed)
    );

    fbc_debounce #(.CNT_W(20), .DB_CYC(DEBOUNCE_CYC)) u_db_remote (
        .core_clk(core_clk),
        .nrst(nrst),
        .raw_n(remote_stop_n),
        .pressed(remote_pressed)
    );

    wire logic stop_lvl = local_pressed | remote_pressed;
    wire logic stop_rel = stop_prev_reg & ~stop_lvl;

    // ------------------------------------------------------------
    // fault log
    // ------------------------------------------------------------
    fbc_log_s log_reg;
    fbc_log_s log_next;
    wire logic evt_service = fault_evt.kind == FBC_KIND_SERVICE;

    always_comb
    begin
        log_next = log_reg;
        // auto-start stop never reaches here, so it leaves the log alone
        if (fault_evt.valid && fault_evt.kind != FBC_KIND_NONE)
        begin
            log_next.first = fault_evt.kind;
            if (evt_service)
            begin
                log_next.first = FBC_KIND_SERVICE;
                log_next.tens = fault_evt.tens;
                log_next.ones = fault_evt.ones;
            end
        end
    end

    // ------------------------------------------------------------
    // control state machine
    // ------------------------------------------------------------
    fbc_state_e state_reg;
    fbc_state_e state_next;
    logic [27:0] gen_cnt_reg;
    logic [27:0] gen_cnt_next;
    logic [1:0] press_reg;
    logic [1:0] press_next;
    logic [35:0] disp_cnt_reg;
    logic disp_start;

    wire logic showing = state_reg == FBC_SHOW1 || state_reg == FBC_SHOW2;
    wire logic disp_done = showing && disp_cnt_reg == TIMEOUT_CYC - 1'b1;
    wire logic [27:0] win_cyc =
        (state_reg == FBC_TMO) ? RESTORE_WIN_CYC : PRESS_WIN_CYC;
    wire logic win_end = gen_cnt_reg == win_cyc - 1'b1;

    always_comb
    begin
        state_next = state_reg;
        gen_cnt_next = gen_cnt_reg;
        press_next = press_reg;
        disp_start = 1'b0;
        case (state_reg)
            FBC_SLEEP:
            begin
                gen_cnt_next = '0;
                if (stop_lvl && gen_cnt_reg == WAKE_CYC - 1'b1)
                    state_next = FBC_WAKE;
                else if (stop_lvl)
                    gen_cnt_next = gen_cnt_reg + 1'b1;
            end
            FBC_WAKE:
            begin
                // the wake press release is not counted as a press
                press_next = 2'h0;
                gen_cnt_next = '0;
                if (stop_rel)
                    state_next = FBC_AWAKE;
            end
            FBC_AWAKE, FBC_TMO:
            begin
                if (stop_rel && press_reg == 2'h2)
                begin
                    state_next = FBC_SHOW1;
                    disp_start = 1'b1;
                    press_next = 2'h0;
                    gen_cnt_next = '0;
                end
                else if (stop_rel)
                begin
                    press_next = press_reg + 2'h1;
                    if (press_reg == 2'h0)
                        gen_cnt_next = '0;
                    else
                        gen_cnt_next = gen_cnt_reg + 1'b1;
                end
                else if (press_reg != 2'h0 && win_end)
                begin
                    press_next = 2'h0;
                    gen_cnt_next = '0;
                end
                else if (press_reg != 2'h0)
                    gen_cnt_next = gen_cnt_reg + 1'b1;
            end
            FBC_SHOW1:
            begin
                if (stop_rel)
                begin
                    state_next = FBC_SHOW2;
                    disp_start = 1'b1;
                end
                else if (disp_done)
                    state_next = FBC_TMO;
            end
            FBC_SHOW2:
            begin
                if (stop_rel)
                    state_next = FBC_AWAKE;
                else if (disp_done)
                    state_next = FBC_TMO;
            end
            default:
                state_next = FBC_SLEEP;
        endcase
    end

    // ------------------------------------------------------------
    // blink sequencer
    // ------------------------------------------------------------
    fbc_phase_e ph_reg;
    fbc_phase_e ph_next;
    logic [27:0] ph_cnt_reg;
    logic [27:0] ph_cnt_next;
    logic [3:0] left_reg;
    logic [3:0] left_next;
    logic dig_reg;
    logic dig_next;

    wire logic tgt2 = state_next == FBC_SHOW2;
    wire logic two = state_reg == FBC_SHOW2;
    wire logic [3:0] first_cnt = {1'b0, log_reg.first};
    wire logic [3:0] tens_cnt = {1'b0, log_reg.tens};
    // tens and first-level digits share the faster rate
    wire logic [27:0] on_cyc = dig_reg ? ONES_ON_CYC : TENS_ON_CYC;
    wire logic [27:0] gap_cyc = dig_reg ? ONES_GAP_CYC : TENS_GAP_CYC;
    wire logic ph_end = ph_cnt_reg == 28'h000_0000;
    wire logic mid_code = two && !dig_reg;
    wire logic [27:0] pause_cyc =
        mid_code ? SHORT_PAUSE_CYC : LONG_PAUSE_CYC;
    wire logic [3:0] next_dig_cnt =
        mid_code ? log_reg.ones : (two ? tens_cnt : first_cnt);
    wire logic [3:0] start_cnt = tgt2 ? tens_cnt : first_cnt;

    always_comb
    begin
        ph_next = ph_reg;
        ph_cnt_next = ph_cnt_reg - 1'b1;
        left_next = left_reg;
        dig_next = dig_reg;
        if (disp_start)
        begin
            dig_next = 1'b0;
            left_next = start_cnt;
            // empty log shows only pauses, lamp stays dark
            ph_next = (start_cnt != 4'h0) ? FBC_PH_ON : FBC_PH_PAUSE;
            ph_cnt_next = (start_cnt != 4'h0) ?
                TENS_ON_CYC - 1'b1 : LONG_PAUSE_CYC - 1'b1;
        end
        else if (!showing)
        begin
            ph_next = FBC_PH_PAUSE;
            ph_cnt_next = ph_cnt_reg;
        end
        else if (ph_end)
        begin
            case (ph_reg)
                FBC_PH_ON:
                begin
                    left_next = left_reg - 4'h1;
                    if (left_reg > 4'h1)
                    begin
                        ph_next = FBC_PH_GAP;
                        ph_cnt_next = gap_cyc - 1'b1;
                    end
                    else
                    begin
                        ph_next = FBC_PH_PAUSE;
                        ph_cnt_next = pause_cyc - 1'b1;
                    end
                end
                FBC_PH_GAP:
                begin
                    ph_next = FBC_PH_ON;
                    ph_cnt_next = on_cyc - 1'b1;
                end
                FBC_PH_PAUSE:
                begin
                    dig_next = mid_code;
                    left_next = next_dig_cnt;
                    if (next_dig_cnt != 4'h0)
                    begin
                        ph_next = FBC_PH_ON;
                        ph_cnt_next =
                            (mid_code ? ONES_ON_CYC : TENS_ON_CYC) - 1'b1;
                    end
                    else
                        ph_cnt_next = LONG_PAUSE_CYC - 1'b1;
                end
                default:
                    ph_next = FBC_PH_PAUSE;
            endcase
        end
    end

    wire logic show_next = state_next == FBC_SHOW1 || tgt2;
    wire logic lamp_next = state_next == FBC_WAKE ||
        (show_next && ph_next == FBC_PH_ON);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= FBC_SLEEP;
            gen_cnt_reg <= '0;
            press_reg <= 2'h0;
            stop_prev_reg <= 1'b0;
            disp_cnt_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            gen_cnt_reg <= gen_cnt_next;
            press_reg <= press_next;
            stop_prev_reg <= stop_lvl;
            // display timer restarts whenever a display level is entered
            disp_cnt_reg <= (disp_start || !showing) ?
                '0 : disp_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ph_reg <= FBC_PH_PAUSE;
            ph_cnt_reg <= '0;
            left_reg <= 4'h0;
            dig_reg <= 1'b0;
            status_lamp <= 1'b0;
        end
        else
        begin
            ph_reg <= ph_next;
            ph_cnt_reg <= ph_cnt_next;
            left_reg <= left_next;
            dig_reg <= dig_next;
            status_lamp <= lamp_next;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            log_reg.first <= `FBC_LOG_FIRST_RST;
            log_reg.tens <= `FBC_LOG_TENS_RST;
            log_reg.ones <= `FBC_LOG_ONES_RST;
            normal_stop <= 1'b0;
            fault_stop <= 1'b0;
        end
        else
        begin
            log_reg <= log_next;
            normal_stop <= auto_stop_req;
            fault_stop <= fault_evt.valid &&
                fault_evt.kind != FBC_KIND_NONE;
        end
    end

    assign fault_log = log_reg;

endmodule : fbc_top

/* File: bench/fbc_operator.sv */
// operator model: local and remote stop/prime switches to ground
`timescale 1ns/1ps

module fbc_operator (
    input wire logic core_clk,
    output logic local_stop_n,
    output logic remote_stop_n
);
    // --------------------------------------------------------
    // switch actions
    // --------------------------------------------------------
    // open switch: the pull-up holds the stop line high
    initial
    begin
        local_stop_n = 1'b1;
        remote_stop_n = 1'b1;
    end

    // closing a switch grounds its stop line
    task press(input logic remote);
        @(posedge core_clk);
        #1;
        if (remote)
            remote_stop_n = 1'b0;
        else
            local_stop_n = 1'b0;
    endtask : press

    // releasing is up to the caller, e.g. once the lamp lights
    task release_all;
        @(posedge core_clk);
        #1;
        local_stop_n = 1'b1;
        remote_stop_n = 1'b1;
    endtask : release_all

    // hold and release both outlast the debounce filter
    task tap(input logic remote);
        press(remote);
        repeat (11) @(posedge core_clk);
        release_all;
        repeat (5) @(posedge core_clk);
        #1;
    endtask : tap
endmodule : fbc_operator

/* File: bench/fbc_top_monitor.sv */
// concurrent checks on the ports of the fault blink code display
`timescale 1ns/1ps

module fbc_top_monitor
    import fbc_pkg::*;
#(
    parameter logic [27:0] TENS_ON_CYC = 28'h0005,
    parameter logic [27:0] TENS_GAP_CYC = 28'h0005
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic auto_stop_req,
    input wire fbc_pkg::fbc_fault_evt_s fault_evt,
    input wire logic status_lamp,
    input wire logic normal_stop,
    input wire logic fault_stop,
    input wire fbc_pkg::fbc_log_s fault_log
);
    // --------------------------------------------------------
    // lamp run lengths
    // --------------------------------------------------------
    logic [27:0] on_run;
    logic [27:0] off_run;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            on_run <= 28'h0;
            off_run <= 28'h0;
        end
        else
        begin
            on_run <= status_lamp ? on_run + 28'h1 : 28'h0;
            off_run <= status_lamp ? 28'h0 : off_run + 28'h1;
        end
    end

    // --------------------------------------------------------
    // properties
    // --------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    sequence fault_in;
        fault_evt.valid && fault_evt.kind != FBC_KIND_NONE;
    endsequence

    sequence service_in;
        fault_evt.valid && fault_evt.kind == FBC_KIND_SERVICE;
    endsequence

    a_stop_pulse: assert property
        (fault_in |=> fault_stop) else $error("fault stop missing");
    a_stop_cause: assert property
        (fault_stop |-> $past(fault_evt.valid)
        && $past(fault_evt.kind) != FBC_KIND_NONE)
        else $error("fault stop without fault");
    a_auto_pulse: assert property
        (auto_stop_req |=> normal_stop) else $error("normal stop missing");
    a_auto_idle: assert property
        (!auto_stop_req |=> !normal_stop) else $error("stray normal stop");
    a_auto_nolog: assert property
        (auto_stop_req && !fault_evt.valid |=> $stable(fault_log))
        else $error("auto stop changed log");
    a_log_first: assert property
        (fault_evt.valid && fault_evt.kind inside
        {FBC_KIND_TEMP, FBC_KIND_OIL, FBC_KIND_CRANK}
        |=> fault_log.first == $past(fault_evt.kind)
        && $stable(fault_log.tens) && $stable(fault_log.ones))
        else $error("first level log wrong");
    a_log_service: assert property
        (service_in |=> fault_log ==
        {3'h3, $past(fault_evt.tens), $past(fault_evt.ones)})
        else $error("service log wrong");
    a_log_hold: assert property
        ((!fault_evt.valid || fault_evt.kind == FBC_KIND_NONE)
        |=> $stable(fault_log)) else $error("log changed");
    a_lamp_on_min: assert property
        ($fell(status_lamp) |-> on_run >= TENS_ON_CYC)
        else $error("lamp on too short");
    a_lamp_off_min: assert property
        ($rose(status_lamp) |-> off_run >= TENS_GAP_CYC)
        else $error("lamp off too short");
endmodule : fbc_top_monitor

bind fbc_top fbc_top_monitor #(
    .TENS_ON_CYC(TENS_ON_CYC), .TENS_GAP_CYC(TENS_GAP_CYC)
) mon_u (
    .core_clk(core_clk), .nrst(nrst), .auto_stop_req(auto_stop_req),
    .fault_evt(fault_evt), .status_lamp(status_lamp),
    .normal_stop(normal_stop), .fault_stop(fault_stop),
    .fault_log(fault_log)
);

/* File: bench/fbc_top_bench.sv */
// self-checking bench for the fault blink code display
`timescale 1ns/1ps

module fbc_top_bench;
    import fbc_pkg::*;
    logic core_clk;
    logic nrst;
    logic auto_stop_req;
    fbc_fault_evt_s fault_evt;
    logic local_stop_n;
    logic remote_stop_n;
    logic status_lamp;
    logic normal_stop;
    logic fault_stop;
    fbc_log_s fault_log;
    int failures;
    int n_tests;

    // --------------------------------------------------------
    // design and operator
    // --------------------------------------------------------
    // short counts: 2000-cycle timeout, 50-cycle long pause
    localparam logic [27:0] WAKE_C = 28'h28, WIN_C = 28'hc8, RWIN_C = 28'h78;
    localparam logic [35:0] TMO_C = 36'h7d0;
    localparam logic [19:0] DB_C = 20'h4;
    localparam int TON = 5, TGAP = 5, OON = 7, OGAP = 7, SP = 20, LP = 50;

    fbc_top #(
        .WAKE_CYC(WAKE_C), .PRESS_WIN_CYC(WIN_C), .RESTORE_WIN_CYC(RWIN_C),
        .TIMEOUT_CYC(TMO_C), .DEBOUNCE_CYC(DB_C), .TENS_ON_CYC(28'(TON)),
        .TENS_GAP_CYC(28'(TGAP)), .ONES_ON_CYC(28'(OON)),
        .ONES_GAP_CYC(28'(OGAP)), .SHORT_PAUSE_CYC(28'(SP)),
        .LONG_PAUSE_CYC(28'(LP))
    ) dut_u (
        .core_clk(core_clk), .nrst(nrst), .local_stop_n(local_stop_n),
        .remote_stop_n(remote_stop_n), .auto_stop_req(auto_stop_req),
        .fault_evt(fault_evt), .status_lamp(status_lamp),
        .normal_stop(normal_stop), .fault_stop(fault_stop),
        .fault_log(fault_log)
    );

    fbc_operator opr_u (
        .core_clk(core_clk), .local_stop_n(local_stop_n),
        .remote_stop_n(remote_stop_n)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // --------------------------------------------------------
    // helpers
    // --------------------------------------------------------
    task end_sim;
        $display("tests=%0d failures=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    task check(input logic [35:0] seen, input logic [35:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    // bounded wait; running out ends the run
    task wait_rise(input int lim);
        int k;
        k = 0;
        while (status_lamp !== 1'b1 && k < lim)
        begin
            tick(1);
            k++;
        end
        if (status_lamp !== 1'b1)
        begin
            check(1'b0, 1'b1);
            end_sim;
        end
    endtask : wait_rise

    task run_len(input logic lv, output int n);
        n = 0;
        while (status_lamp === lv && n < 3000)
        begin
            n++;
            tick(1);
        end
    endtask : run_len

    task count_high(input int cyc, output int n);
        n = 0;
        repeat (cyc)
        begin
            if (status_lamp === 1'b1)
                n++;
            tick(1);
        end
    endtask : count_high

    // one group of blinks, starting at its first lit cycle
    task group(input int nb, input int on, input int gap, input int pause);
        int len;
        for (int i = 0; i < nb; i++)
        begin
            run_len(1'b1, len);
            check(36'(len), 36'(on));
            run_len(1'b0, len);
            check(36'(len), 36'((i == nb - 1) ? pause : gap));
        end
    endtask : group

    task taps3(input logic remote);
        opr_u.tap(1'b0);
        opr_u.tap(remote);
        opr_u.tap(1'b0);
    endtask : taps3

    // --------------------------------------------------------
    // scenarios
    // --------------------------------------------------------
    task t_faults;
        fbc_kind_e kinds [4];
        fbc_log_s exp;
        kinds = '{FBC_KIND_TEMP, FBC_KIND_OIL, FBC_KIND_CRANK,
            FBC_KIND_SERVICE};
        exp = '0;
        check(36'(fault_log), 36'h0);
        foreach (kinds[i])
        begin
            fault_evt = {1'b1, kinds[i], 3'h3, 4'h6};
            exp.first = kinds[i];
            if (kinds[i] == FBC_KIND_SERVICE)
                exp = {3'h3, 3'h3, 4'h6};
            tick(1);
            fault_evt = '0;
            check(fault_stop, 1'b1);
            check(36'(fault_log), 36'(exp));
            tick(1);
            check(fault_stop, 1'b0);
        end
        fault_evt = {1'b1, FBC_KIND_NONE, 3'h1, 4'h1};
        tick(1);
        fault_evt = '0;
        check(36'(fault_log), 36'(exp));
        auto_stop_req = 1'b1;
        tick(1);
        auto_stop_req = 1'b0;
        check(normal_stop, 1'b1);
        check(fault_stop, 1'b0);
        check(36'(fault_log), 36'(exp));
    endtask : t_faults

    task t_wake;
        opr_u.press(1'b0);
        tick(40);
        check(status_lamp, 1'b0);
        wait_rise(40);
        opr_u.release_all;
        tick(30);
        check(status_lamp, 1'b0);
    endtask : t_wake

    task t_show;
        int n;
        taps3(1'b1);
        wait_rise(5);
        group(3, TON, TGAP, LP);
        tick(15);
        opr_u.tap(1'b0);
        wait_rise(60);
        group(3, TON, TGAP, SP);
        group(6, OON, OGAP, LP);
        // end the display inside the short pause, clear of any lit phase
        tick(10);
        opr_u.tap(1'b0);
        tick(30);
        count_high(200, n);
        check(36'(n), 36'h0);
    endtask : t_show

    task t_timeout;
        int n;
        taps3(1'b0);
        wait_rise(5);
        tick(1900);
        count_high(100, n);
        check(36'(n != 0), 36'h1);
        tick(150);
        count_high(200, n);
        check(36'(n), 36'h0);
    endtask : t_timeout

    task t_restore;
        int n;
        opr_u.tap(1'b0);
        tick(50);
        opr_u.tap(1'b1);
        tick(50);
        opr_u.tap(1'b0);
        count_high(30, n);
        check(36'(n), 36'h0);
        tick(150);
        taps3(1'b1);
        wait_rise(5);
        group(3, TON, TGAP, LP);
    endtask : t_restore

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial
    begin
        failures = 0;
        n_tests = 0;
        nrst = 1'b0;
        auto_stop_req = 1'b0;
        fault_evt = '0;
        tick(20);
        nrst = 1'b1;
        tick(2);
        t_faults;
        t_wake;
        t_show;
        t_timeout;
        t_restore;
        end_sim;
    end
endmodule : fbc_top_bench
